// ---- logic/context_entry_decoder.sv ----
// context entry decoder: entry table, lookup engine, avalon slave
// assumes software fills the table and keeps reserved bits zero
`default_nettype none
module context_entry_decoder #(
  parameter int HOST_ADDR_WIDTH = 46
) (
  input wire logic ref_clk, // 50 mhz clock
  input wire logic rst_b, // async reset, low
  input wire logic [9:0] avs_address, // byte address
  input wire logic avs_read, // read strobe
  input wire logic avs_write, // write strobe
  input wire logic [3:0] avs_byteenable, // byte lanes
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall, high by default
  output logic irq // level interrupt
);
  localparam logic [63:0] HOST_MASK =
    (64'h1 << HOST_ADDR_WIDTH) - 64'h1; // kept host bits

  ////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic inWindow(input logic [9:0] a);
    return a >= ctx_pkg::OFF_WINDOW;
  endfunction

  function automatic logic [31:0] mergeBe(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // bus handshake state
  typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_ANS} bus_type;
  bus_type busQ, busD; // handshake phase
  logic waitQ, waitD; // waitrequest flop
  logic [31:0] rdQ, rdD; // readdata flop
  logic [9:0] addrQ, addrD; // latched address
  logic [31:0] readMux; // selected read value
  logic accept; // request taken this cycle
  logic wrAcc; // write taken this cycle
  logic busMem; // bus owns the table port

  assign accept = (busQ == BUS_IDLE) && (avs_read || avs_write);
  assign wrAcc = accept && avs_write;
  assign busMem = accept && inWindow(avs_address);

  // lookup and register state
  typedef enum logic [1:0] {F_IDLE, F_ISSUE, F_CAPT, F_FIN} fetch_type;
  fetch_type fetchQ, fetchD; // lookup phase
  logic [1:0] wordQ, wordD; // word being fetched
  logic [2:0][31:0] wQ, wD; // fetched entry words
  logic [31:0] reqQ, reqD; // lookup request
  logic [2:0] ctrlQ, ctrlD; // mode and capabilities
  logic [1:0] maskQ, maskD; // interrupt mask
  logic [1:0] statQ, statD; // sticky events
  logic irqQ, irqD; // interrupt flop
  logic [15:0] faultCntQ, faultCntD; // recorded faults
  ctx_pkg::decode_type resQ, resD; // last outcome
  ctx_pkg::decode_type dec; // outcome being formed
  logic faultHit; // a fault arose
  logic [1:0] events; // this cycle's events
  logic [1:0] w1c; // software clear bits

  // table port
  logic [ctx_pkg::MEM_AW-1:0] memAddr; // shared address
  logic [31:0] memRdata; // registered read data

  assign memAddr = busMem ? avs_address[ctx_pkg::MEM_AW+1:2] :
    {reqQ[ctx_pkg::IDX_W-1:0], 1'b0, wordQ};

  ctx_entry_mem #(.WIDTH(32), .AW(ctx_pkg::MEM_AW)) u_mem (
    .clk(ref_clk),
    .we(busMem && avs_write),
    .be(avs_byteenable),
    .addr(memAddr),
    .wdata(avs_writedata),
    .rdata(memRdata)
  );

  ////////////////////////////////////////////////////////////////////
  // read selection, from the latched address
  always_comb begin
    readMux = 32'h0;
    if (inWindow(addrQ)) begin
      readMux = memRdata;
    end else begin
      unique case (addrQ)
        ctx_pkg::OFF_CTRL: readMux = {29'h0, ctrlQ};
        ctx_pkg::OFF_REQ: readMux = reqQ;
        ctx_pkg::OFF_STATUS: readMux = {25'h0, resQ.exec, resQ.priv,
          resQ.untagged, resQ.faultRecorded, resQ.suppress,
          resQ.present, fetchQ != F_IDLE};
        ctx_pkg::OFF_PID: readMux = {12'h0, resQ.pid};
        ctx_pkg::OFF_BASE_LO: readMux = resQ.base[31:0];
        ctx_pkg::OFF_BASE_HI: readMux = resQ.base[63:32];
        ctx_pkg::OFF_DIR: begin
          // entry count, zero when no directory applies
          if (resQ.present && resQ.scalable) begin
            readMux = 32'h1 << resQ.dirLog2;
          end
        end
        ctx_pkg::OFF_IRQ_STAT: readMux = {30'h0, statQ};
        ctx_pkg::OFF_IRQ_MASK: readMux = {30'h0, maskQ};
        ctx_pkg::OFF_FAULT_CNT: readMux = {16'h0, faultCntQ};
        default: readMux = 32'h0; // unmapped reads zero
      endcase
    end
  end

  // handshake: take, one wait cycle, answer
  always_comb begin
    busD = busQ;
    waitD = 1'b1;
    rdD = rdQ;
    addrD = addrQ;
    unique case (busQ)
      BUS_IDLE: begin
        if (accept) begin
          busD = BUS_WAIT;
          addrD = avs_address;
        end
      end
      BUS_WAIT: begin
        busD = BUS_ANS;
        waitD = 1'b0;
        rdD = avs_read ? readMux : 32'h0;
      end
      BUS_ANS: busD = BUS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busQ <= BUS_IDLE;
      waitQ <= 1'b1;
      rdQ <= 32'h0;
      addrQ <= 10'h0;
    end else begin
      busQ <= busD;
      waitQ <= waitD;
      rdQ <= rdD;
      addrQ <= addrD;
    end
  end

  assign avs_waitrequest = waitQ;
  assign avs_readdata = rdQ;

  ////////////////////////////////////////////////////////////////////
  // entry decode from the fetched words
  always_comb begin
    dec = '0;
    dec.present = wQ[0][ctx_pkg::PRESENT_BIT];
    dec.suppress = wQ[0][ctx_pkg::SUPPRESS_BIT];
    dec.untagged = reqQ[ctx_pkg::REQ_UNTAGGED];
    dec.scalable = ctrlQ[ctx_pkg::CTRL_SCALABLE];
    // absent entry keeps priv, exec, pid, base and dirLog2 zero
    if (dec.present) begin
      dec.priv = reqQ[ctx_pkg::REQ_PRIV];
      dec.exec = reqQ[ctx_pkg::REQ_EXEC];
      dec.pid = reqQ[31:ctx_pkg::REQ_PID_LSB];
      if (dec.scalable) begin
        // host physical base, upper bits dropped
        dec.base = {wQ[1], wQ[0][31:ctx_pkg::BASE_LSB], 12'h0}
          & HOST_MASK;
        dec.dirLog2 = {1'b0, wQ[0][ctx_pkg::DIR_SIZE_LSB +: 3]}
          + ctx_pkg::DIR_SIZE_BIAS;
        if (dec.untagged) begin
          dec.exec = 1'b0;
          // default id only when the capability is there
          dec.pid = ctrlQ[ctx_pkg::CTRL_PID_CAP] ?
            wQ[2][ctx_pkg::W2_PID_LSB +: 20] : 20'h0;
          // privileged rights only when the capability is there
          dec.priv = ctrlQ[ctx_pkg::CTRL_PRIV_CAP] &
            wQ[2][ctx_pkg::W2_PRIV_BIT];
        end
      end
    end
    faultHit = !dec.present || reqQ[ctx_pkg::REQ_FAULT];
    dec.faultRecorded = faultHit && !dec.suppress;
  end

  // lookup engine and software registers
  always_comb begin
    fetchD = fetchQ;
    wordD = wordQ;
    wD = wQ;
    reqD = reqQ;
    ctrlD = ctrlQ;
    maskD = maskQ;
    resD = resQ;
    faultCntD = faultCntQ;
    events = 2'h0;
    w1c = 2'h0;
    // software writes, taken with the request
    if (wrAcc) begin
      unique case (avs_address)
        ctx_pkg::OFF_CTRL: ctrlD = 3'(mergeBe({29'h0, ctrlQ},
          avs_writedata, avs_byteenable));
        ctx_pkg::OFF_IRQ_MASK: maskD = 2'(mergeBe({30'h0, maskQ},
          avs_writedata, avs_byteenable));
        ctx_pkg::OFF_IRQ_STAT: begin
          if (avs_byteenable[0]) begin
            w1c = avs_writedata[1:0];
          end
        end
        ctx_pkg::OFF_REQ: begin
          // a new lookup only while idle
          if (fetchQ == F_IDLE) begin
            reqD = mergeBe(reqQ, avs_writedata, avs_byteenable);
            wordD = 2'h0;
            fetchD = F_ISSUE;
          end
        end
        default: ; // other writes ignored
      endcase
    end
    unique case (fetchQ)
      F_IDLE: ;
      F_ISSUE: begin
        // the bus has the port first
        if (!busMem) begin
          fetchD = F_CAPT;
        end
      end
      F_CAPT: begin
        wD[wordQ] = memRdata;
        if (wordQ == ctx_pkg::LAST_WORD) begin
          fetchD = F_FIN;
        end else begin
          wordD = wordQ + 2'h1;
          fetchD = F_ISSUE;
        end
      end
      F_FIN: begin
        resD = dec;
        events[ctx_pkg::IRQ_DONE] = 1'b1;
        // suppressed faults leave no trace
        if (dec.faultRecorded) begin
          events[ctx_pkg::IRQ_FAULT] = 1'b1;
          faultCntD = faultCntQ + 16'h1;
        end
        fetchD = F_IDLE;
      end
    endcase
    // a new event beats a clear in the same cycle
    statD = (statQ & ~w1c) | events;
    irqD = |(statD & maskD);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fetchQ <= F_IDLE;
      wordQ <= 2'h0;
      wQ <= '0;
      reqQ <= 32'h0;
      ctrlQ <= ctx_pkg::CTRL_RST;
      maskQ <= ctx_pkg::MASK_RST;
      statQ <= 2'h0;
      irqQ <= 1'b0;
      faultCntQ <= 16'h0;
      resQ <= '0;
    end else begin
      fetchQ <= fetchD;
      wordQ <= wordD;
      wQ <= wD;
      reqQ <= reqD;
      ctrlQ <= ctrlD;
      maskQ <= maskD;
      statQ <= statD;
      irqQ <= irqD;
      faultCntQ <= faultCntD;
      resQ <= resD;
    end
  end

  assign irq = irqQ;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_fin;
    fetchQ == F_FIN;
  endsequence
  sequence s_untagged_sm;
    s_fin ##0 (dec.present && dec.scalable && dec.untagged);
  endsequence

  property p_record;
    s_fin ##0 (!dec.present && !dec.suppress) |=>
      resQ.faultRecorded && statQ[ctx_pkg::IRQ_FAULT]
      && faultCntQ == $past(faultCntQ) + 16'h1;
  endproperty
  a_record: assert property (p_record)
    else $error("unsuppressed fault not recorded");

  property p_suppress;
    s_fin ##0 dec.suppress |=>
      !resQ.faultRecorded && faultCntQ == $past(faultCntQ);
  endproperty
  a_suppress: assert property (p_suppress)
    else $error("suppressed fault was recorded");

  property p_suppress_absent;
    s_fin ##0 (!dec.present && wQ[0][ctx_pkg::SUPPRESS_BIT]) |=>
      resQ.suppress && !resQ.faultRecorded;
  endproperty
  a_suppress_absent: assert property (p_suppress_absent)
    else $error("suppress ignored on absent entry");

  property p_absent;
    s_fin ##0 !dec.present |=>
      resQ.pid == 20'h0 && resQ.base == 64'h0 && !resQ.priv;
  endproperty
  a_absent: assert property (p_absent)
    else $error("absent entry fields used");

  property p_exec;
    s_untagged_sm |=> !resQ.exec;
  endproperty
  a_exec: assert property (p_exec)
    else $error("execute not forced to zero");

  property p_priv;
    s_untagged_sm |=> resQ.priv == ($past(ctrlQ[ctx_pkg::CTRL_PRIV_CAP])
      && $past(wQ[2][ctx_pkg::W2_PRIV_BIT]));
  endproperty
  a_priv: assert property (p_priv)
    else $error("default privilege wrong");

  property p_priv_nocap;
    s_untagged_sm ##0 !ctrlQ[ctx_pkg::CTRL_PRIV_CAP] |=> !resQ.priv;
  endproperty
  a_priv_nocap: assert property (p_priv_nocap)
    else $error("privilege used without capability");

  property p_pid;
    s_untagged_sm ##0 ctrlQ[ctx_pkg::CTRL_PID_CAP] |=>
      resQ.pid == $past(wQ[2][19:0]);
  endproperty
  a_pid: assert property (p_pid)
    else $error("default id not taken");

  property p_pid_nocap;
    s_untagged_sm ##0 !ctrlQ[ctx_pkg::CTRL_PID_CAP] |=>
      resQ.pid == 20'h0;
  endproperty
  a_pid_nocap: assert property (p_pid_nocap)
    else $error("id used without capability");

  property p_base;
    (resQ.base & ~HOST_MASK) == 64'h0 && resQ.base[11:0] == 12'h0;
  endproperty
  a_base: assert property (p_base)
    else $error("base bits outside host width");

  property p_dir;
    s_fin ##0 (dec.present && dec.scalable) |=>
      resQ.dirLog2 == {1'b0, $past(wQ[0][11:9])} + 4'h7;
  endproperty
  a_dir: assert property (p_dir)
    else $error("directory size decode wrong");

  property p_bus;
    accept |=> avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus answer timing wrong");
endmodule
`default_nettype wire

// ---- logic/ctx_pkg.sv ----
// shared constants and types of the context entry decoder
// assumes a 32-bit avalon slave with byte addresses
`default_nettype none
package ctx_pkg;
  // bus map, byte offsets
  localparam int ADDR_W = 10;
  localparam logic [9:0] OFF_CTRL = 10'h000;
  localparam logic [9:0] OFF_REQ = 10'h004;
  localparam logic [9:0] OFF_STATUS = 10'h008;
  localparam logic [9:0] OFF_PID = 10'h00c;
  localparam logic [9:0] OFF_BASE_LO = 10'h010;
  localparam logic [9:0] OFF_BASE_HI = 10'h014;
  localparam logic [9:0] OFF_DIR = 10'h018;
  localparam logic [9:0] OFF_IRQ_STAT = 10'h01c;
  localparam logic [9:0] OFF_IRQ_MASK = 10'h020;
  localparam logic [9:0] OFF_FAULT_CNT = 10'h024;
  localparam logic [9:0] OFF_WINDOW = 10'h200;
  // entry table geometry
  localparam int IDX_W = 4;
  localparam int WORD_W = 3;
  localparam int MEM_AW = IDX_W + WORD_W;
  localparam logic [1:0] LAST_WORD = 2'h2;
  // entry fields in words 0 and 2
  localparam int PRESENT_BIT = 0;
  localparam int SUPPRESS_BIT = 1;
  localparam int DIR_SIZE_LSB = 9;
  localparam int BASE_LSB = 12;
  localparam int W2_PID_LSB = 0;
  localparam int W2_PRIV_BIT = 20;
  localparam logic [3:0] DIR_SIZE_BIAS = 4'h7;
  // control bits
  localparam int CTRL_SCALABLE = 0;
  localparam int CTRL_PRIV_CAP = 1;
  localparam int CTRL_PID_CAP = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // request bits
  localparam int REQ_UNTAGGED = 8;
  localparam int REQ_EXEC = 9;
  localparam int REQ_PRIV = 10;
  localparam int REQ_FAULT = 11;
  localparam int REQ_PID_LSB = 12;
  // interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAULT = 1;
  localparam logic [1:0] MASK_RST = 2'h0;
  // decoded outcome of one lookup
  typedef struct packed {
    logic present;
    logic suppress;
    logic faultRecorded;
    logic scalable;
    logic untagged;
    logic priv;
    logic exec;
    logic [19:0] pid;
    logic [63:0] base;
    logic [3:0] dirLog2;
  } decode_type;
endpackage
`default_nettype wire

// ---- logic/ctx_entry_mem.sv ----
// entry table storage, one port, byte lane writes
// assumes one clock; read data registered, one cycle late
`default_nettype none
module ctx_entry_mem #(
  parameter int WIDTH = 32,
  parameter int AW = 7
) (
  input wire logic clk, // clock
  input wire logic we, // write this cycle
  input wire logic [WIDTH/8-1:0] be, // byte lanes
  input wire logic [AW-1:0] addr, // word address
  input wire logic [WIDTH-1:0] wdata, // write data
  output logic [WIDTH-1:0] rdata // registered read data
);
  // one storage array per byte lane, so each has a single writer
  for (genvar i = 0; i < WIDTH / 8; i++) begin : g_lane
    logic [7:0] lane [2**AW]; // this lane's bytes
    logic [7:0] laneQ; // registered read byte
    // lane write and registered read
    always_ff @(posedge clk) begin
      if (we && be[i]) begin
        lane[addr] <= wdata[i*8 +: 8];
      end
      laneQ <= lane[addr];
    end
    assign rdata[i*8 +: 8] = laneQ;
  end
endmodule
`default_nettype wire

// ---- tb/entry_table_model.sv ----
// software-built entry table image for the decoder bench
// assumes the bench copies these words into the entry window
`default_nettype none
module entry_table_model;
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////
  logic [31:0] word0 [16]; // entry bits 31:0
  logic [31:0] word1 [16]; // entry bits 63:32
  logic [31:0] word2 [16]; // entry bits 95:64
  // fills one entry with random fields
  task automatic build(input int idx);
    word0[idx] = $urandom;
    word1[idx] = $urandom;
    word2[idx] = $urandom & 32'h001f_ffff;
  endtask
endmodule
`default_nettype wire

// ---- tb/test_context_entry_decoder.sv ----
// bench: random entries and lookups, checked against a model
// assumes the design package and the entry table model are compiled
`default_nettype none
module test_context_entry_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOST_W = 40; // narrower host width to expose masking
  logic refClk; // 50 mhz clock
  logic rstB; // reset, low
  logic [9:0] addr; // bus address
  logic rd; // read strobe
  logic wr; // write strobe
  logic [3:0] be; // byte lanes
  logic [31:0] wdata; // write data
  logic [31:0] rdata; // read data
  logic waitReq; // slave stall
  logic irq; // interrupt level
  int errTotal = 0; // mismatches
  int numChecks = 0; // comparisons
  int faults = 0; // expected fault count
  logic [1:0] irqStat; // expected sticky status
  logic [1:0] mask; // current mask
  ////////////////////////////////////////////////////////////
  context_entry_decoder #(.HOST_ADDR_WIDTH(HOST_W)) dut (
    .ref_clk(refClk),
    .rst_b(rstB),
    .avs_address(addr),
    .avs_read(rd),
    .avs_write(wr),
    .avs_byteenable(be),
    .avs_writedata(wdata),
    .avs_readdata(rdata),
    .avs_waitrequest(waitReq),
    .irq(irq)
  );
  entry_table_model tables();
  // free-running clock
  always #10 refClk = ~refClk;
  ////////////////////////////////////////////////////////////
  // one comparison, counted
  task automatic chk(input string what, input logic [63:0] seen,
                     input logic [63:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic isWr, input logic [9:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge refClk);
    addr <= a;
    wr <= isWr;
    rd <= !isWr;
    wdata <= d;
    // wait for the slave; only the watchdog ends a hang
    do begin
      @(posedge refClk);
    end while (waitReq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // read one register and compare
  task automatic rdChk(input string what, input logic [9:0] a,
                       input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, {32'h0, q}, {32'h0, exp});
  endtask
  // write one register
  task automatic wr32(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  ////////////////////////////////////////////////////////////
  // one lookup: start, wait, compare every result register
  task automatic lookup(input logic [31:0] ctrl, input logic [31:0] req);
    logic [31:0] w0, w1, w2, q, dir;
    logic pres, sup, rec, unt, pri, exe, sc;
    logic [19:0] pid;
    logic [63:0] base;
    int n;
    w0 = tables.word0[req[3:0]];
    w1 = tables.word1[req[3:0]];
    w2 = tables.word2[req[3:0]];
    pres = w0[0];
    sup = w0[1];
    sc = ctrl[0];
    unt = req[8];
    pid = req[31:12];
    pri = req[10];
    exe = req[9];
    rec = (!pres || req[11]) && !sup;
    // untagged scalable: defaults from the entry
    if (pres && sc && unt) begin
      exe = 1'b0;
      pid = ctrl[2] ? w2[19:0] : 20'h0;
      pri = ctrl[1] ? w2[20] : 1'b0;
    end
    base = {w1, w0[31:12], 12'h000} & ((64'h1 << HOST_W) - 64'h1);
    dir = 32'h1 << (w0[11:9] + 7);
    // absent or legacy: no directory fields
    if (!(pres && sc)) begin
      base = 64'h0;
      dir = 32'h0;
    end
    // absent: entry-derived fields zero, untagged view kept from request
    if (!pres) begin
      pri = 1'b0;
      exe = 1'b0;
      pid = 20'h0;
    end
    if (rec) begin
      faults++;
    end
    irqStat = irqStat | {rec, 1'b1};
    wr32(ctx_pkg::OFF_CTRL, ctrl);
    wr32(ctx_pkg::OFF_REQ, req);
    n = 0;
    do begin
      bus(1'b0, ctx_pkg::OFF_STATUS, 32'h0, q);
      n++;
    end while (q[0] !== 1'b0 && n < 20);
    chk("status", {32'h0, q}, {57'h0, exe, pri, unt, rec, sup, pres,
        1'b0});
    rdChk("pid", ctx_pkg::OFF_PID, {12'h0, pid});
    rdChk("base lo", ctx_pkg::OFF_BASE_LO, base[31:0]);
    rdChk("base hi", ctx_pkg::OFF_BASE_HI, base[63:32]);
    rdChk("dir", ctx_pkg::OFF_DIR, dir);
    rdChk("faults", ctx_pkg::OFF_FAULT_CNT, 32'(faults[15:0]));
    rdChk("irq stat", ctx_pkg::OFF_IRQ_STAT, {30'h0, irqStat});
    chk("irq", {63'h0, irq}, {63'h0, |(irqStat & mask)});
  endtask
  ////////////////////////////////////////////////////////////
  // watchdog: about five times the expected run of some 4000 cycles
  initial begin
    #400000;
    errTotal++;
    close_out();
  end
  // main sequence
  initial begin
    logic [1:0] clr;
    refClk = 1'b0;
    rstB = 1'b0;
    addr = 10'h000;
    rd = 1'b0;
    wr = 1'b0;
    be = 4'hf;
    wdata = 32'h0;
    irqStat = 2'h0;
    mask = 2'h0;
    void'($urandom(32'h977a));
    repeat (4) @(posedge refClk);
    rstB <= 1'b1;
    rdChk("ctrl reset", ctx_pkg::OFF_CTRL, 32'h0);
    rdChk("mask reset", ctx_pkg::OFF_IRQ_MASK, 32'h0);
    rdChk("unmapped", 10'h0fc, 32'h0);
    // a write with lane 0 off leaves the control bits alone
    be <= 4'he;
    wr32(ctx_pkg::OFF_CTRL, 32'h7);
    be <= 4'hf;
    rdChk("ctrl lanes", ctx_pkg::OFF_CTRL, 32'h0);
    // software builds and loads the whole table
    for (int i = 0; i < 16; i++) begin
      tables.build(i);
      wr32(ctx_pkg::OFF_WINDOW + 10'(i * 32), tables.word0[i]);
      wr32(ctx_pkg::OFF_WINDOW + 10'(i * 32 + 4), tables.word1[i]);
      wr32(ctx_pkg::OFF_WINDOW + 10'(i * 32 + 8), tables.word2[i]);
    end
    // one word read back through the table window
    rdChk("window", ctx_pkg::OFF_WINDOW + 10'h8, tables.word2[0]);
    // random lookups with masking and clearing between them
    for (int t = 0; t < 60; t++) begin
      lookup($urandom & 32'h7, $urandom & 32'hffff_ff0f);
      mask = 2'($urandom);
      wr32(ctx_pkg::OFF_IRQ_MASK, {30'h0, mask});
      rdChk("mask", ctx_pkg::OFF_IRQ_MASK, {30'h0, mask});
      chk("irq masked", {63'h0, irq}, {63'h0, |(irqStat & mask)});
      clr = 2'($urandom);
      wr32(ctx_pkg::OFF_IRQ_STAT, {30'h0, clr});
      irqStat = irqStat & ~clr;
      rdChk("irq clear", ctx_pkg::OFF_IRQ_STAT, {30'h0, irqStat});
      chk("irq after clear", {63'h0, irq}, {63'h0, |(irqStat & mask)});
    end
    close_out();
  end
endmodule
`default_nettype wire
